// >>> design/sd_cmd_framer.sv
`timescale 1ns/1ns
// Contract
// - Every command goes out as exactly 48 bits, one per card clock.
// - Command frame: start 0, direction 1, index, argument, CRC7, end 1.
// - Command output is released whenever the path is not transmitting.
// - Line is driven and sampled on the rising card clock edge.
// - Command and response never overlap; the line is half-duplex.
// - Receiver takes a 48-bit or 136-bit response by expected type.
// - Short response: start 0, direction 0, index, argument, CRC7 or ones, end 1.
// - Long response: start 0, direction 0, six ones, 127 register bits, end 1.
// - Fast I/O index 39 carries address, flag, register, data; expects R4.
// - Go-interrupt index 40 is broadcast with response, answered by R5.
// - Lock index 42 is addressed data transfer answered by R1b.
// - Application prefix index 55 carries card address and gets R1.
// - General index 56 uses argument bit 0 to pick transfer direction.
// - Broadcast draws no response; broadcast with response gets all cards answering.
// - Addressed commands go to the selected card, with or without data.
// - Broadcast commands only for old multimedia cards; addressed target one.
// - Responses arrive most significant bit first, length set by type.
// - All responses carry CRC except the operating-conditions type with ones; the code checks CRC7 on every short and long response, ones included.
module sd_cmd_framer (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic card_clk_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input sd_cmd_pkg::cmd_req_t cmd_req_i,
    output logic resp_valid_o,
    output sd_cmd_pkg::cmd_resp_t resp_o,
    input wire logic cmd_i,
    output logic cmd_o,
    output logic cmd_oe_n_o
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic busy;
        sd_cmd_pkg::cmd_req_t req;
        logic req_tgl;
        logic [2:0] done_sync;
        logic done_acc;
        logic resp_valid;
        sd_cmd_pkg::cmd_resp_t resp;
    } sys_state_t;

    typedef struct packed {
        logic [2:0] rst_sync;
        logic [2:0] req_sync;
        logic req_acc;
        sd_cmd_pkg::link_state_t state;
        sd_cmd_pkg::resp_kind_t kind;
        logic [47:0] txsr;
        logic [135:0] rxsr;
        logic [7:0] pos;
        logic [7:0] tcnt;
        logic [6:0] crc;
        logic dout;
        logic crc_err;
        logic end_err;
        logic timeout;
        logic done_tgl;
    } link_state_t;

    sys_state_t st_s;
    sys_state_t next_s;
    link_state_t st_l;
    link_state_t next_l;
    logic link_rst;
    logic sys_done_acc;
    logic sys_done_ev;
    logic link_req_acc;
    logic link_req_ev;
    logic [6:0] link_crc;
    logic link_in_crc;
    logic [7:0] link_len;

    assign link_rst = st_l.rst_sync[2];

    // --------------------------------------------------------------
    // System clock domain
    // --------------------------------------------------------------
    always_comb begin
        next_s = st_s;
        next_s.resp_valid = 1'h0;
        next_s.done_sync = {st_s.done_sync[1:0], st_l.done_tgl};
        sys_done_acc = (st_s.done_sync[1] == st_s.done_sync[2]) ? st_s.done_sync[2]
            : st_s.done_acc;
        sys_done_ev = sys_done_acc != st_s.done_acc;
        next_s.done_acc = sys_done_acc;
        if (!st_s.busy && cmd_valid_i) begin
            next_s.busy = 1'h1;
            next_s.req = cmd_req_i;
            if (cmd_req_i.kind == sd_cmd_pkg::RESP_AUTO) begin
                next_s.req.kind = sd_cmd_pkg::auto_kind(cmd_req_i.index);
            end
            next_s.req_tgl = ~st_s.req_tgl;
        end
        if (st_s.busy && sys_done_ev) begin
            next_s.busy = 1'h0;
            next_s.resp_valid = 1'h1;
            next_s.resp.frame = st_l.rxsr;
            next_s.resp.crc_fail = st_l.crc_err;
            next_s.resp.end_fail = st_l.end_err;
            next_s.resp.timeout = st_l.timeout;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_s <= '0;
        end else begin
            st_s <= next_s;
        end
    end

    assign cmd_ready_o = !st_s.busy;
    assign resp_valid_o = st_s.resp_valid;
    assign resp_o = st_s.resp;

    // --------------------------------------------------------------
    // Card clock domain
    // --------------------------------------------------------------
    always_comb begin
        next_l = st_l;
        link_crc = st_l.crc;
        link_in_crc = 1'h0;
        link_len = (st_l.kind == sd_cmd_pkg::RESP_LONG) ? sd_cmd_pkg::LONG_LEN
            : sd_cmd_pkg::SHORT_LEN;
        next_l.rst_sync = {st_l.rst_sync[1:0], sys_rst_i};
        next_l.req_sync = {st_l.req_sync[1:0], st_s.req_tgl};
        link_req_acc = (st_l.req_sync[1] == st_l.req_sync[2]) ? st_l.req_sync[2]
            : st_l.req_acc;
        link_req_ev = link_req_acc != st_l.req_acc;
        next_l.req_acc = link_req_acc;
        case (st_l.state)
            sd_cmd_pkg::L_IDLE: begin
                if (link_req_ev) begin
                    next_l.state = sd_cmd_pkg::L_TX;
                    next_l.kind = st_s.req.kind;
                    next_l.txsr = {sd_cmd_pkg::START_BIT, sd_cmd_pkg::DIR_HOST, st_s.req.index,
                        st_s.req.arg, sd_cmd_pkg::CRC7_INIT, sd_cmd_pkg::END_BIT};
                    next_l.pos = sd_cmd_pkg::SHORT_LEN - 8'h01;
                    next_l.crc = sd_cmd_pkg::CRC7_INIT;
                    next_l.dout = sd_cmd_pkg::START_BIT;
                    next_l.rxsr = '0;
                    next_l.crc_err = 1'h0;
                    next_l.end_err = 1'h0;
                    next_l.timeout = 1'h0;
                end
            end
            sd_cmd_pkg::L_TX: begin
                if (st_l.pos >= sd_cmd_pkg::CRC_LOW_POS) begin
                    link_crc = sd_cmd_pkg::crc7_step(st_l.crc, st_l.dout);
                end else begin
                    link_crc = {st_l.crc[5:0], 1'h0};
                end
                next_l.crc = link_crc;
                next_l.txsr = {st_l.txsr[46:0], 1'h0};
                next_l.pos = st_l.pos - 8'h01;
                if (st_l.pos > sd_cmd_pkg::CRC_LOW_POS) begin
                    next_l.dout = st_l.txsr[46];
                end else if (st_l.pos > 8'h01) begin
                    next_l.dout = link_crc[6];
                end else begin
                    next_l.dout = sd_cmd_pkg::END_BIT;
                end
                if (st_l.pos == 8'h00) begin
                    next_l.dout = sd_cmd_pkg::LINE_IDLE;
                    next_l.tcnt = 8'h00;
                    if (st_l.kind == sd_cmd_pkg::RESP_NONE) begin
                        next_l.state = sd_cmd_pkg::L_DONE;
                    end else begin
                        next_l.state = sd_cmd_pkg::L_WAIT;
                    end
                end
            end
            sd_cmd_pkg::L_WAIT: begin
                // The card drives the line on this same clock, so it is sampled directly.
                if (cmd_i == sd_cmd_pkg::START_BIT) begin
                    next_l.state = sd_cmd_pkg::L_RX;
                    next_l.pos = link_len - 8'h02;
                    next_l.crc = sd_cmd_pkg::CRC7_INIT;
                    next_l.rxsr = '0;
                end else if (st_l.tcnt == sd_cmd_pkg::RESP_TIMEOUT_CYC - 8'h01) begin
                    next_l.timeout = 1'h1;
                    next_l.state = sd_cmd_pkg::L_DONE;
                end else begin
                    next_l.tcnt = st_l.tcnt + 8'h01;
                end
            end
            sd_cmd_pkg::L_RX: begin
                next_l.rxsr = {st_l.rxsr[134:0], cmd_i};
                next_l.pos = st_l.pos - 8'h01;
                link_in_crc = (st_l.pos >= sd_cmd_pkg::CRC_LOW_POS)
                    && ((st_l.kind != sd_cmd_pkg::RESP_LONG)
                    || (st_l.pos <= sd_cmd_pkg::LONG_CRC_TOP));
                if (link_in_crc) begin
                    next_l.crc = sd_cmd_pkg::crc7_step(st_l.crc, cmd_i);
                end else if (st_l.pos >= 8'h01 && st_l.pos < sd_cmd_pkg::CRC_LOW_POS) begin
                    next_l.crc = {st_l.crc[5:0], 1'h0};
                    if (cmd_i != st_l.crc[6]) begin
                        next_l.crc_err = 1'h1;
                    end
                end
                if (st_l.pos == 8'h00) begin
                    next_l.end_err = cmd_i != sd_cmd_pkg::END_BIT;
                    next_l.state = sd_cmd_pkg::L_DONE;
                end
            end
            sd_cmd_pkg::L_DONE: begin
                next_l.done_tgl = ~st_l.done_tgl;
                next_l.state = sd_cmd_pkg::L_IDLE;
            end
            default: begin
                next_l.state = sd_cmd_pkg::L_IDLE;
            end
        endcase
        if (link_rst) begin
            next_l = '0;
            next_l.rst_sync = {st_l.rst_sync[1:0], sys_rst_i};
            next_l.req_sync = {st_l.req_sync[1:0], st_s.req_tgl};
            next_l.dout = sd_cmd_pkg::LINE_IDLE;
            next_l.state = sd_cmd_pkg::L_IDLE;
        end
    end

    always_ff @(posedge card_clk_i) begin
        st_l <= next_l;
    end

    assign cmd_o = st_l.dout;
    assign cmd_oe_n_o = st_l.state != sd_cmd_pkg::L_TX;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    logic [7:0] tx_cycles;
    logic [7:0] rx_cycles;

    always_ff @(posedge card_clk_i) begin
        if (st_l.state == sd_cmd_pkg::L_TX) begin
            tx_cycles <= tx_cycles + 8'h01;
        end else begin
            tx_cycles <= 8'h00;
        end
        if (st_l.state == sd_cmd_pkg::L_WAIT) begin
            rx_cycles <= 8'h01;
        end else if (st_l.state == sd_cmd_pkg::L_RX) begin
            rx_cycles <= rx_cycles + 8'h01;
        end
    end

    property p_tx_len;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state == sd_cmd_pkg::L_TX && st_l.pos == 8'h00) |-> tx_cycles == 8'h2F;
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("Command frame not 48 bits.");

    property p_frame_head;
        @(posedge card_clk_i) disable iff (link_rst)
        $rose(st_l.state == sd_cmd_pkg::L_TX) |-> !cmd_o ##1 cmd_o ##6 (cmd_o == $past(st_s.req.index[0]));
    endproperty
    a_frame_head: assert property (p_frame_head) else $error("Command head bits wrong.");

    property p_frame_end;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state == sd_cmd_pkg::L_TX && st_l.pos == 8'h00) |-> cmd_o;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("Command end bit not one.");

    property p_release;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state != sd_cmd_pkg::L_TX) |-> cmd_oe_n_o;
    endproperty
    a_release: assert property (p_release) else $error("Line driven outside transmit.");

    property p_half_duplex;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state == sd_cmd_pkg::L_TX && st_l.pos == 8'h00) |=> cmd_oe_n_o [*2];
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("Line not released after frame.");

    property p_crc_tx;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state == sd_cmd_pkg::L_TX && st_l.pos == 8'h07)
            |-> st_l.crc == sd_cmd_pkg::crc7_40({2'h1, st_s.req.index, st_s.req.arg});
    endproperty
    a_crc_tx: assert property (p_crc_tx) else $error("Command CRC7 wrong.");

    property p_resp_len;
        @(posedge card_clk_i) disable iff (link_rst)
        ($past(st_l.state) == sd_cmd_pkg::L_RX && st_l.state == sd_cmd_pkg::L_DONE)
            |-> rx_cycles == link_len;
    endproperty
    a_resp_len: assert property (p_resp_len) else $error("Response length wrong.");

    property p_no_resp;
        @(posedge card_clk_i) disable iff (link_rst)
        (st_l.state == sd_cmd_pkg::L_TX && st_l.pos == 8'h00
            && st_l.kind == sd_cmd_pkg::RESP_NONE) |=> st_l.state == sd_cmd_pkg::L_DONE;
    endproperty
    a_no_resp: assert property (p_no_resp) else $error("Broadcast waited for response.");

    property p_crc_flag;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (resp_valid_o && st_s.req.kind == sd_cmd_pkg::RESP_SHORT && !resp_o.timeout)
            |-> resp_o.crc_fail
            == (sd_cmd_pkg::crc7_40(resp_o.frame[47:8]) != resp_o.frame[7:1]);
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("CRC status wrong.");

    property p_auto_kind;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (cmd_valid_i && cmd_ready_o && cmd_req_i.kind == sd_cmd_pkg::RESP_AUTO
            && cmd_req_i.index == sd_cmd_pkg::IDX_FAST_IO)
            |=> st_s.req.kind == sd_cmd_pkg::RESP_SHORT;
    endproperty
    a_auto_kind: assert property (p_auto_kind) else $error("Fast I/O not short response.");

    property p_cov_short;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        resp_valid_o && st_s.req.kind == sd_cmd_pkg::RESP_SHORT && !resp_o.timeout;
    endproperty
    c_cov_short: cover property (p_cov_short);

    property p_cov_long;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        resp_valid_o && st_s.req.kind == sd_cmd_pkg::RESP_LONG && !resp_o.timeout;
    endproperty
    c_cov_long: cover property (p_cov_long);

    property p_cov_none;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        resp_valid_o && st_s.req.kind == sd_cmd_pkg::RESP_NONE;
    endproperty
    c_cov_none: cover property (p_cov_none);

    property p_cov_timeout;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        resp_valid_o && resp_o.timeout;
    endproperty
    c_cov_timeout: cover property (p_cov_timeout);

endmodule // sd_cmd_framer

// >>> design/sd_cmd_pkg.sv
package sd_cmd_pkg;

    // --------------------------------------------------------------
    // Frame geometry and timing
    // --------------------------------------------------------------
    localparam logic [7:0] SHORT_LEN = 8'h30;
    localparam logic [7:0] LONG_LEN = 8'h88;
    localparam logic [7:0] CRC_LOW_POS = 8'h08;
    localparam logic [7:0] LONG_CRC_TOP = 8'h7F;
    localparam logic [7:0] RESP_TIMEOUT_CYC = 8'h40;
    localparam logic [6:0] CRC7_POLY = 7'h09;
    localparam logic [6:0] CRC7_INIT = 7'h00;
    localparam logic START_BIT = 1'h0;
    localparam logic DIR_HOST = 1'h1;
    localparam logic END_BIT = 1'h1;
    localparam logic LINE_IDLE = 1'h1;

    // --------------------------------------------------------------
    // Command indices with a fixed response class
    // --------------------------------------------------------------
    localparam logic [5:0] IDX_FAST_IO = 6'h27;
    localparam logic [5:0] IDX_GO_IRQ = 6'h28;
    localparam logic [5:0] IDX_LOCK = 6'h2A;
    localparam logic [5:0] IDX_APP_PREFIX = 6'h37;
    localparam logic [5:0] IDX_GENERAL = 6'h38;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        RESP_NONE = 2'h0,
        RESP_SHORT = 2'h1,
        RESP_LONG = 2'h2,
        RESP_AUTO = 2'h3
    } resp_kind_t;

    typedef enum logic [2:0] {
        L_IDLE = 3'h0,
        L_TX = 3'h1,
        L_WAIT = 3'h2,
        L_RX = 3'h3,
        L_DONE = 3'h4
    } link_state_t;

    typedef struct packed {
        logic [5:0] index;
        logic [31:0] arg;
        resp_kind_t kind;
    } cmd_req_t;

    typedef struct packed {
        logic [135:0] frame;
        logic crc_fail;
        logic end_fail;
        logic timeout;
    } cmd_resp_t;

    // --------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------
    function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic b);
        logic fb;
        fb = b ^ crc[6];
        crc7_step = {crc[5:0], 1'h0} ^ (fb ? CRC7_POLY : 7'h00);
    endfunction

    function automatic logic [6:0] crc7_40(input logic [39:0] d);
        logic [6:0] c;
        c = CRC7_INIT;
        for (int i = 39; i >= 0; i--) begin
            c = crc7_step(c, d[i]);
        end
        crc7_40 = c;
    endfunction

    function automatic resp_kind_t auto_kind(input logic [5:0] idx);
        case (idx)
            IDX_FAST_IO, IDX_GO_IRQ, IDX_LOCK, IDX_APP_PREFIX, IDX_GENERAL: begin
                auto_kind = RESP_SHORT;
            end
            default: begin
                auto_kind = RESP_NONE;
            end
        endcase
    endfunction

endpackage

// >>> tb/sd_card_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Card-side model of the command line
// ----------------------------------------------------------------
module sd_card_model (
    input wire logic card_clk_i,
    input wire logic line_i,
    input wire logic [135:0] reply_i,
    input wire logic [7:0] reply_len_i,
    input wire logic [7:0] reply_gap_i,
    output logic drv_o,
    output logic drv_en_o,
    output logic [47:0] cmd_seen_o
);
    logic [7:0] rx_cnt;
    logic [7:0] tx_cnt;
    logic [7:0] gap_cnt;
    logic [47:0] rx_sh;
    logic [135:0] tx_sh;

    initial begin
        rx_cnt = 8'h00;
        tx_cnt = 8'h00;
        gap_cnt = 8'h00;
        drv_o = 1'b1;
        drv_en_o = 1'b0;
        cmd_seen_o = 48'h0;
    end

    // The line is sampled and driven on the rising card clock edge.
    always @(posedge card_clk_i) begin
        if (tx_cnt != 8'h00) begin
            drv_en_o <= 1'b1;
            drv_o <= tx_sh[135];
            tx_sh <= tx_sh << 1;
            tx_cnt <= tx_cnt - 8'h01;
        end else if (drv_en_o) begin
            drv_en_o <= 1'b0;
            drv_o <= ~drv_o;
        end else if (gap_cnt != 8'h00) begin
            gap_cnt <= gap_cnt - 8'h01;
            if (gap_cnt == 8'h01) begin
                tx_sh <= reply_i << (8'h88 - reply_len_i);
                tx_cnt <= reply_len_i;
            end
        end else if (rx_cnt != 8'h00) begin
            rx_sh <= {rx_sh[46:0], line_i};
            rx_cnt <= rx_cnt + 8'h01;
            if (rx_cnt == 8'h2F) begin
                cmd_seen_o <= {rx_sh[46:0], line_i};
                rx_cnt <= 8'h00;
                // The reply waits until the host has released the line.
                if (reply_len_i != 8'h00) begin
                    gap_cnt <= reply_gap_i + 8'h01;
                end
            end
        end else if (line_i === 1'b0) begin
            rx_cnt <= 8'h01;
            rx_sh <= 48'h0;
        end
    end
endmodule // sd_card_model

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_sys_i = 1'b0;
    logic card_clk = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid = 1'b0;
    sd_cmd_pkg::cmd_req_t cmd_req = '0;
    logic cmd_ready_o;
    logic resp_valid_o;
    sd_cmd_pkg::cmd_resp_t resp_o;
    logic cmd_o;
    logic cmd_oe_n_o;
    logic card_bit;
    logic card_en;
    logic cmd_line;
    logic [47:0] cmd_seen;
    logic [135:0] reply = '0;
    logic [7:0] reply_len = 8'h00;
    logic [7:0] reply_gap = 8'h00;
    int failures = 0;
    int n_tests = 0;

    // ------------------------------------------------------------
    // Clocks, line and instances
    // ------------------------------------------------------------
    always #2 clk_sys_i = ~clk_sys_i;
    initial begin
        #5;
        forever #16 card_clk = ~card_clk;
    end

    // The line has a pull-up when neither side drives it.
    assign cmd_line = (cmd_oe_n_o === 1'b0) ? cmd_o : (card_en ? card_bit : 1'b1);

    sd_cmd_framer dut_u (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .card_clk_i(card_clk),
        .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready_o),
        .cmd_req_i(cmd_req),
        .resp_valid_o(resp_valid_o),
        .resp_o(resp_o),
        .cmd_i(cmd_line),
        .cmd_o(cmd_o),
        .cmd_oe_n_o(cmd_oe_n_o)
    );

    sd_card_model card_u (
        .card_clk_i(card_clk),
        .line_i(cmd_line),
        .reply_i(reply),
        .reply_len_i(reply_len),
        .reply_gap_i(reply_gap),
        .drv_o(card_bit),
        .drv_en_o(card_en),
        .cmd_seen_o(cmd_seen)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [135:0] seen, input logic [135:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
        logic [6:0] c;
        c = 7'h00;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    function automatic logic [135:0] short_resp(input logic [5:0] idx, input logic [31:0] arg,
            input logic good_crc, input logic end_bit);
        logic [6:0] c;
        c = good_crc ? crc7({80'h0, 2'h0, idx, arg}, 40) : 7'h7F;
        return {88'h0, 2'h0, idx, arg, c, end_bit};
    endfunction

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Sends one command, tries a refused request meanwhile, judges the result.
    task automatic do_cmd(input logic [5:0] idx, input logic [31:0] arg,
            input sd_cmd_pkg::resp_kind_t kind, input logic [7:0] rlen,
            input logic [135:0] rframe, input logic [7:0] gap, input logic [2:0] flags);
        logic [47:0] cframe;
        int n;
        cframe = {2'h1, idx, arg, crc7({80'h0, 2'h1, idx, arg}, 40), 1'b1};
        reply_len = rlen;
        reply = rframe;
        reply_gap = gap;
        @(negedge clk_sys_i);
        cmd_valid = 1'b1;
        cmd_req = '{index: idx, arg: arg, kind: kind};
        @(negedge clk_sys_i);
        cmd_req.index = ~idx;
        repeat (4) begin
            check("ready_busy", cmd_ready_o, 0);
            @(negedge clk_sys_i);
        end
        cmd_valid = 1'b0;
        n = 0;
        while (resp_valid_o !== 1'b1 && n < 8000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("done", resp_valid_o, 1);
        check("ready_back", cmd_ready_o, 1);
        check("cmd_frame", cmd_seen, cframe);
        check("resp_frame", resp_o.frame, (rlen != 8'h00) ? rframe : 136'h0);
        check("flags", {resp_o.crc_fail, resp_o.end_fail, resp_o.timeout}, flags);
        check("line_released", cmd_oe_n_o, 1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_no_reply();
        do_cmd(6'h00, 32'hFFFFFFFF, sd_cmd_pkg::RESP_NONE, 8'h00, 136'h0, 8'h00, 3'h0);
        do_cmd(6'h3F, 32'h00000000, sd_cmd_pkg::RESP_AUTO, 8'h00, 136'h0, 8'h00, 3'h0);
    endtask

    task automatic t_auto_short();
        logic [5:0] idx[5];
        logic [31:0] arg[5];
        idx = '{sd_cmd_pkg::IDX_FAST_IO, sd_cmd_pkg::IDX_GO_IRQ, sd_cmd_pkg::IDX_LOCK,
                sd_cmd_pkg::IDX_APP_PREFIX, sd_cmd_pkg::IDX_GENERAL};
        arg = '{{16'h1234, 1'b1, 7'h55, 8'hA5}, 32'h00000000, 32'h0000FFFF,
                {16'h1234, 16'h0000}, 32'h00000001};
        for (int i = 0; i < 5; i++) begin
            do_cmd(idx[i], arg[i], sd_cmd_pkg::RESP_AUTO, 8'h30,
                   short_resp(idx[i], ~arg[i], 1'b1, 1'b1), 8'(i * 12), 3'h0);
        end
    endtask

    task automatic t_long();
        logic [119:0] d;
        d = {4{30'h2AC3_5F1E}};
        do_cmd(6'h02, 32'h0, sd_cmd_pkg::RESP_LONG, 8'h88,
               {2'h0, 6'h3F, d, crc7(d, 120), 1'b1}, 8'h30, 3'h0);
    endtask

    task automatic t_faults();
        do_cmd(6'h01, 32'h00FF8000, sd_cmd_pkg::RESP_SHORT, 8'h30,
               short_resp(6'h3F, 32'h80FF8000, 1'b0, 1'b1), 8'h05, 3'h4);
        do_cmd(6'h0D, 32'h12340000, sd_cmd_pkg::RESP_SHORT, 8'h30,
               short_resp(6'h0D, 32'h00000900, 1'b1, 1'b0), 8'h01, 3'h2);
        do_cmd(6'h0D, 32'h12340000, sd_cmd_pkg::RESP_SHORT, 8'h00, 136'h0, 8'h00, 3'h1);
    endtask

    // ------------------------------------------------------------
    // Line watch, watchdog and main sequence
    // ------------------------------------------------------------
    always @(posedge card_clk) begin
        if (cmd_oe_n_o === 1'b0 && card_en === 1'b1) begin
            check("line_overlap", 1, 0);
        end
    end

    initial begin
        #300000;
        failures++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge card_clk);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        t_no_reply();
        t_auto_short();
        t_long();
        t_faults();
        summarize();
    end
endmodule // tb
